// file: rtl/tpt_trace_port.sv
// trace port: registers one retire record per clock for outside observers
// assumes retire, cache and pipeline inputs come from core logic on clock_i
// What this block does
// RULE1: valid strobe qualifies instruction and pc fields
// RULE2: register-write flag for file write-back
// RULE3: destination number and value beside flag
// RULE4: exception-taken flag for taken exceptions
// RULE5: exception kind meaningful only with taken
// RULE6: synchronous exception kind codes 00000-00111
// RULE7: interrupt and break kind codes
// RULE8: storage and translation-miss kind codes
// RULE9: reserved kind codes never emitted
// RULE10: jump-taken flag for taken branches
// RULE11: delay-slot flag for taken branch slot
// RULE12: data access flag, address, value, enables
// RULE13: read or write direction per access
// RULE14: data cacheable range and hit
// RULE15: instruction cacheable range and hit
// RULE16: decode, execute, memory advance strobes
// RULE17: execute strobe unused when area optimized
// RULE18: observers should use supplied analysis logic
// RULE19: outputs driven from clock, sampled same edge
`timescale 1ns/1ps
`include "tpt_defs.svh"

module tpt_trace_port #(
  parameter bit AREA_OPT = 1'b0
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       ret_valid_i,
  input  wire logic [`TPT_WORD_W-1:0]     ret_instr_i,
  input  wire logic [`TPT_WORD_W-1:0]     ret_pc_i,
  input  wire logic                       ret_wb_en_i,
  input  wire logic [`TPT_REGNUM_W-1:0]   ret_wb_num_i,
  input  wire logic [`TPT_WORD_W-1:0]     ret_wb_value_i,
  input  wire logic [`TPT_STATUS_W-1:0]   ret_status_i,
  input  wire logic [`TPT_PID_W-1:0]      ret_pid_i,
  input  wire logic                       ret_exc_i,
  input  wire tpt_pkg::tpt_kind_t         ret_exc_kind_i,
  input  wire logic                       ret_branch_taken_i,
  input  wire logic                       ret_delay_slot_i,
  input  wire logic                       dacc_valid_i,
  input  wire logic [`TPT_WORD_W-1:0]     dacc_addr_i,
  input  wire logic [`TPT_WORD_W-1:0]     dacc_wdata_i,
  input  wire logic [`TPT_BE_W-1:0]       dacc_be_i,
  input  wire logic                       dacc_read_i,
  input  wire logic                       dacc_write_i,
  input  wire logic                       dcache_on_i,
  input  wire logic [`TPT_WORD_W-1:0]     dcache_base_i,
  input  wire logic [`TPT_WORD_W-1:0]     dcache_high_i,
  input  wire logic                       dcache_hit_i,
  input  wire logic [`TPT_WORD_W-1:0]     fetch_addr_i,
  input  wire logic                       icache_on_i,
  input  wire logic [`TPT_WORD_W-1:0]     icache_base_i,
  input  wire logic [`TPT_WORD_W-1:0]     icache_high_i,
  input  wire logic                       icache_hit_i,
  input  wire logic                       decode_run_i,
  input  wire logic                       execute_run_i,
  input  wire logic                       memstage_run_i,
  output logic                            trc_valid_instr_o,
  output logic [`TPT_WORD_W-1:0]          trc_instruction_o,
  output logic [`TPT_WORD_W-1:0]          trc_program_counter_o,
  output logic                            trc_reg_write_o,
  output logic [`TPT_REGNUM_W-1:0]        trc_reg_num_o,
  output logic [`TPT_WORD_W-1:0]          trc_reg_value_o,
  output logic [`TPT_STATUS_W-1:0]        trc_status_snapshot_o,
  output logic [`TPT_PID_W-1:0]           trc_process_id_o,
  output logic                            trc_exc_taken_o,
  output tpt_pkg::tpt_kind_t              trc_exc_kind_o,
  output logic                            trc_kind_fault_o,
  output logic                            trc_jump_taken_o,
  output logic                            trc_delay_slot_o,
  output logic                            trc_data_access_o,
  output logic [`TPT_WORD_W-1:0]          trc_data_addr_o,
  output logic [`TPT_WORD_W-1:0]          trc_data_wvalue_o,
  output logic [`TPT_BE_W-1:0]            trc_data_be_o,
  output logic                            trc_data_read_o,
  output logic                            trc_data_write_o,
  output logic                            trc_dside_cacheable_o,
  output logic                            trc_dside_hit_o,
  output logic                            trc_iside_cacheable_o,
  output logic                            trc_iside_hit_o,
  output logic                            trc_decode_advance_o,
  output logic                            trc_execute_advance_o,
  output logic                            trc_memstage_advance_o
);
  import tpt_pkg::*;

  logic nxt_kind_ok;
  logic nxt_dcacheable;
  logic nxt_icacheable;
  logic nxt_dacc;

  assign nxt_kind_ok    = tpt_kind_legal(ret_exc_kind_i);
  // RULE14: range compare inclusive
  assign nxt_dcacheable = dcache_on_i && (dacc_addr_i >= dcache_base_i) && (dacc_addr_i <= dcache_high_i);
  // RULE15: range compare inclusive
  assign nxt_icacheable = icache_on_i && (fetch_addr_i >= icache_base_i) && (fetch_addr_i <= icache_high_i);
  // access needs a direction, else nothing to report
  assign nxt_dacc       = ret_valid_i && dacc_valid_i && (dacc_read_i ^ dacc_write_i);

  // RULE1: valid strobe and code
  // RULE19: all fields from clock_i
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_valid_instr_o     <= `TPT_RST_BIT;
      trc_instruction_o     <= `TPT_RST_WORD;
      trc_program_counter_o <= `TPT_RST_WORD;
      trc_status_snapshot_o <= `TPT_RST_STATUS;
      trc_process_id_o      <= `TPT_RST_PID;
    end else begin
      trc_valid_instr_o <= ret_valid_i;
      // fields held when idle so observers see a stable value
      if (ret_valid_i) begin
        trc_instruction_o     <= ret_instr_i;
        trc_program_counter_o <= ret_pc_i;
        trc_status_snapshot_o <= ret_status_i;
        trc_process_id_o      <= ret_pid_i;
      end
    end
  end

  // RULE2: write-back flag
  // RULE3: number and value
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_reg_write_o <= `TPT_RST_BIT;
      trc_reg_num_o   <= `TPT_RST_REGNUM;
      trc_reg_value_o <= `TPT_RST_WORD;
    end else begin
      trc_reg_write_o <= ret_valid_i && ret_wb_en_i;
      if (ret_valid_i && ret_wb_en_i) begin
        trc_reg_num_o   <= ret_wb_num_i;
        trc_reg_value_o <= ret_wb_value_i;
      end
    end
  end

  // RULE4: exception flag
  // RULE9: reserved kind suppressed
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_exc_taken_o  <= `TPT_RST_BIT;
      trc_exc_kind_o   <= TPT_EXC_STREAM_LINK;
      trc_kind_fault_o <= `TPT_RST_BIT;
    end else begin
      // a reserved code is an internal fault; never shown as an exception
      trc_exc_taken_o  <= ret_valid_i && ret_exc_i && nxt_kind_ok;
      trc_kind_fault_o <= ret_valid_i && ret_exc_i && !nxt_kind_ok;
      // RULE5: kind only with taken
      // RULE6: RULE7: RULE8: legal codes pass
      if (ret_valid_i && ret_exc_i && nxt_kind_ok) begin
        trc_exc_kind_o <= ret_exc_kind_i;
      end
    end
  end

  // RULE10: taken branch flag
  // RULE11: delay slot flag
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_jump_taken_o <= `TPT_RST_BIT;
      trc_delay_slot_o <= `TPT_RST_BIT;
    end else begin
      trc_jump_taken_o <= ret_valid_i && ret_branch_taken_i;
      trc_delay_slot_o <= ret_valid_i && ret_delay_slot_i;
    end
  end

  // RULE12: data access record
  // RULE13: direction flags
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_data_access_o <= `TPT_RST_BIT;
      trc_data_read_o   <= `TPT_RST_BIT;
      trc_data_write_o  <= `TPT_RST_BIT;
      trc_data_addr_o   <= `TPT_RST_WORD;
      trc_data_wvalue_o <= `TPT_RST_WORD;
      trc_data_be_o     <= `TPT_RST_BE;
    end else begin
      trc_data_access_o <= nxt_dacc;
      trc_data_read_o   <= nxt_dacc && dacc_read_i;
      trc_data_write_o  <= nxt_dacc && dacc_write_i;
      if (nxt_dacc) begin
        trc_data_addr_o   <= dacc_addr_i;
        trc_data_wvalue_o <= dacc_wdata_i;
        trc_data_be_o     <= dacc_be_i;
      end
    end
  end

  // RULE14: data range and hit
  // RULE15: fetch range and hit
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_dside_cacheable_o <= `TPT_RST_BIT;
      trc_dside_hit_o       <= `TPT_RST_BIT;
      trc_iside_cacheable_o <= `TPT_RST_BIT;
      trc_iside_hit_o       <= `TPT_RST_BIT;
    end else begin
      trc_dside_cacheable_o <= nxt_dcacheable;
      // a hit outside the range cannot be real
      trc_dside_hit_o       <= nxt_dcacheable && dcache_hit_i;
      trc_iside_cacheable_o <= nxt_icacheable;
      trc_iside_hit_o       <= nxt_icacheable && icache_hit_i;
    end
  end

  // RULE16: stage advance strobes
  // RULE17: execute strobe held low
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trc_decode_advance_o   <= `TPT_RST_BIT;
      trc_execute_advance_o  <= `TPT_RST_BIT;
      trc_memstage_advance_o <= `TPT_RST_BIT;
    end else begin
      trc_decode_advance_o   <= decode_run_i;
      trc_execute_advance_o  <= !AREA_OPT && execute_run_i;
      trc_memstage_advance_o <= memstage_run_i;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  AST_VALID_FOLLOWS: assert property ($past(ret_valid_i) |-> trc_valid_instr_o) // RULE1
    else $error("valid strobe missed a retire");
  AST_PC_CAPTURED: assert property (ret_valid_i |=> trc_program_counter_o == $past(ret_pc_i)) // RULE1
    else $error("program counter not captured");
  AST_WB_VALUE: assert property (ret_valid_i && ret_wb_en_i |=> trc_reg_write_o
      && trc_reg_value_o == $past(ret_wb_value_i) && trc_reg_num_o == $past(ret_wb_num_i)) // RULE3
    else $error("write-back record wrong");
  AST_WB_NEEDS_VALID: assert property (trc_reg_write_o |-> trc_valid_instr_o) // RULE2
    else $error("register write without valid");
  AST_EXC_NEEDS_VALID: assert property (trc_exc_taken_o |-> trc_valid_instr_o) // RULE4
    else $error("exception without valid");
  AST_KIND_LEGAL: assert property (trc_exc_taken_o |-> tpt_kind_legal(trc_exc_kind_o)) // RULE9
    else $error("reserved exception kind shown");
  AST_KIND_CAPTURED: assert property (ret_valid_i && ret_exc_i && tpt_kind_legal(ret_exc_kind_i)
      |=> trc_exc_taken_o && trc_exc_kind_o == $past(ret_exc_kind_i)) // RULE5
    else $error("exception kind not captured");
  AST_DIR_ONEHOT: assert property (trc_data_access_o |-> (trc_data_read_o ^ trc_data_write_o)) // RULE13
    else $error("data access direction not one-hot");
  AST_DACC_ADDR: assert property (nxt_dacc |=> trc_data_access_o && trc_data_addr_o == $past(dacc_addr_i)
      && trc_data_be_o == $past(dacc_be_i)) // RULE12
    else $error("data access record wrong");
  AST_DHIT_IN_RANGE: assert property (trc_dside_hit_o |-> trc_dside_cacheable_o) // RULE14
    else $error("data hit outside cacheable range");
  AST_IHIT_IN_RANGE: assert property (trc_iside_hit_o |-> trc_iside_cacheable_o) // RULE15
    else $error("instruction hit outside cacheable range");
  AST_STAGE_STROBES: assert property (trc_decode_advance_o == $past(decode_run_i)
      && trc_memstage_advance_o == $past(memstage_run_i)) // RULE16
    else $error("stage strobe not one cycle behind");
  AST_EXEC_AREA: assert property (AREA_OPT |-> !trc_execute_advance_o) // RULE17
    else $error("execute strobe active in area build");
  AST_BRANCH_FLAGS: assert property (ret_valid_i |=> trc_jump_taken_o == $past(ret_branch_taken_i)
      && trc_delay_slot_o == $past(ret_delay_slot_i)) // RULE10
    else $error("branch flags wrong");

  // retire record qualification
  AST_VALID_IDLE: assert property (!ret_valid_i |=> !trc_valid_instr_o) // RULE1
    else $error("valid strobe without a retire");

  AST_INSTR_CAPTURED: assert property (ret_valid_i
      |=> trc_instruction_o == $past(ret_instr_i)) // RULE1
    else $error("instruction code not captured");

  AST_STATUS_CAPTURED: assert property (ret_valid_i |=> trc_status_snapshot_o == $past(ret_status_i)
      && trc_process_id_o == $past(ret_pid_i)) // RULE1
    else $error("status or process id not captured");

  // held fields keep observers from seeing junk between retires
  AST_FIELDS_HOLD: assert property (!ret_valid_i
      |=> $stable(trc_instruction_o) && $stable(trc_program_counter_o)) // RULE1
    else $error("instruction fields moved without a retire");

  // write-back record
  AST_WB_IDLE: assert property (!(ret_valid_i && ret_wb_en_i) |=> !trc_reg_write_o) // RULE2
    else $error("register write flag without a write-back");

  AST_WB_HOLD: assert property (!(ret_valid_i && ret_wb_en_i)
      |=> $stable(trc_reg_value_o) && $stable(trc_reg_num_o)) // RULE3
    else $error("write-back fields moved without a write-back");

  // exception record
  AST_EXC_IDLE: assert property (!(ret_valid_i && ret_exc_i)
      |=> !trc_exc_taken_o && !trc_kind_fault_o) // RULE4
    else $error("exception flag without an exception");

  AST_EXC_RESERVED: assert property (ret_valid_i && ret_exc_i && !tpt_kind_legal(ret_exc_kind_i)
      |=> !trc_exc_taken_o && trc_kind_fault_o && $stable(trc_exc_kind_o)) // RULE9
    else $error("reserved kind not suppressed");

  AST_FAULT_NEEDS_VALID: assert property (trc_kind_fault_o |-> trc_valid_instr_o) // RULE9
    else $error("kind fault without valid");

  AST_KIND_DIVZERO: assert property (ret_valid_i && ret_exc_i && ret_exc_kind_i == 5'h05
      |=> trc_exc_taken_o && trc_exc_kind_o == 5'h05) // RULE6
    else $error("divide by zero kind not passed");

  AST_KIND_INTR: assert property (ret_valid_i && ret_exc_i && ret_exc_kind_i == 5'h0a
      |=> trc_exc_taken_o && trc_exc_kind_o == 5'h0a) // RULE7
    else $error("interrupt kind not passed");

  AST_KIND_DTLB: assert property (ret_valid_i && ret_exc_i && ret_exc_kind_i == 5'h12
      |=> trc_exc_taken_o && trc_exc_kind_o == 5'h12) // RULE8
    else $error("translation miss kind not passed");

  // branch flags
  AST_JUMP_IDLE: assert property (!ret_valid_i
      |=> !trc_jump_taken_o && !trc_delay_slot_o) // RULE11
    else $error("branch flags without a retire");

  // data access record
  AST_DACC_IDLE: assert property (!nxt_dacc
      |=> !trc_data_access_o && !trc_data_read_o && !trc_data_write_o) // RULE13
    else $error("data access flags without an access");

  AST_DACC_WVALUE: assert property (nxt_dacc |=> trc_data_wvalue_o == $past(dacc_wdata_i)
      && trc_data_read_o == $past(dacc_read_i)) // RULE12
    else $error("data write value or direction wrong");

  AST_DACC_NEEDS_VALID: assert property (trc_data_access_o |-> trc_valid_instr_o) // RULE12
    else $error("data access without valid");

  // cache range and hit indications
  AST_DRANGE: assert property (trc_dside_cacheable_o == $past(nxt_dcacheable)
      && trc_dside_hit_o == $past(nxt_dcacheable && dcache_hit_i)) // RULE14
    else $error("data cacheable or hit wrong");

  AST_IRANGE: assert property (trc_iside_cacheable_o == $past(nxt_icacheable)
      && trc_iside_hit_o == $past(nxt_icacheable && icache_hit_i)) // RULE15
    else $error("instruction cacheable or hit wrong");

  // stage strobes
  AST_EXEC_FOLLOWS: assert property (!AREA_OPT
      |-> trc_execute_advance_o == $past(execute_run_i)) // RULE16
    else $error("execute strobe not one cycle behind");

endmodule

// file: pkg/tpt_defs.svh
// reset values and field widths of the trace port
// assumes inclusion by name from design files only
`ifndef TPT_DEFS_SVH
`define TPT_DEFS_SVH

`define TPT_WORD_W      32
`define TPT_REGNUM_W    5
`define TPT_STATUS_W    15
`define TPT_PID_W       8
`define TPT_KIND_W      5
`define TPT_BE_W        4

`define TPT_RST_WORD    32'h0000_0000
`define TPT_RST_REGNUM  5'h00
`define TPT_RST_STATUS  15'h0000
`define TPT_RST_PID     8'h00
`define TPT_RST_BE      4'h0
`define TPT_RST_BIT     1'b0

`endif

// file: pkg/tpt_pkg.sv
// types of the trace port: exception kind codes
// assumes nothing beyond the defs header
`include "tpt_defs.svh"

package tpt_pkg;

  typedef logic [`TPT_KIND_W-1:0] tpt_kind_t;

  typedef enum logic [`TPT_KIND_W-1:0] {
    TPT_EXC_STREAM_LINK  = 5'b00000,
    TPT_EXC_UNALIGNED    = 5'b00001,
    TPT_EXC_ILL_OPCODE   = 5'b00010,
    TPT_EXC_IBUS_ERR     = 5'b00011,
    TPT_EXC_DBUS_ERR     = 5'b00100,
    TPT_EXC_DIV_ZERO     = 5'b00101,
    TPT_EXC_FLOAT        = 5'b00110,
    TPT_EXC_PRIVILEGED   = 5'b00111,
    TPT_EXC_INTERRUPT    = 5'b01010,
    TPT_EXC_BREAK_NMI    = 5'b01011,
    TPT_EXC_BREAK_MASK   = 5'b01100,
    TPT_EXC_DATA_STORE   = 5'b10000,
    TPT_EXC_INSTR_STORE  = 5'b10001,
    TPT_EXC_DTLB_MISS    = 5'b10010,
    TPT_EXC_ITLB_MISS    = 5'b10011
  } tpt_exc_e;

  function automatic logic tpt_kind_legal(input tpt_kind_t k);
    logic ok;
    ok = 1'b0;
    case (k)
      TPT_EXC_STREAM_LINK, TPT_EXC_UNALIGNED, TPT_EXC_ILL_OPCODE, TPT_EXC_IBUS_ERR,
      TPT_EXC_DBUS_ERR, TPT_EXC_DIV_ZERO, TPT_EXC_FLOAT, TPT_EXC_PRIVILEGED,
      TPT_EXC_INTERRUPT, TPT_EXC_BREAK_NMI, TPT_EXC_BREAK_MASK, TPT_EXC_DATA_STORE,
      TPT_EXC_INSTR_STORE, TPT_EXC_DTLB_MISS, TPT_EXC_ITLB_MISS: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

// file: bench/tpt_trace_sink.sv
// trace capture model: counts retires and taken exceptions on the port
// assumes it samples on the same clock edge that drives the port
`timescale 1ns/1ps

module tpt_trace_sink (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        valid_i,
  input  wire logic        exc_taken_i,
  output logic [15:0]      retire_cnt_o,
  output logic [15:0]      exc_cnt_o
);
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) retire_cnt_o <= 16'h0000;
    else if (valid_i) retire_cnt_o <= retire_cnt_o + 16'h0001;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) exc_cnt_o <= 16'h0000;
    else if (valid_i && exc_taken_i) exc_cnt_o <= exc_cnt_o + 16'h0001;
  end
endmodule

// file: bench/tpt_trace_port_tb.sv
// testbench of the trace port: random retire records, queued expectations
// assumes the port answers one cycle after its inputs, AREA_OPT left at 0
`timescale 1ns/1ps

module tpt_trace_port_tb;
  import tpt_pkg::*;
  typedef struct {
    logic [86:0] w;
    logic [14:0] f;
    logic [36:0] wb;
    logic [4:0]  kind;
    logic [67:0] d;
  } tpt_note_s;
  logic clock_i, rst_b_i, ret_valid_i, ret_wb_en_i, ret_exc_i, ret_branch_taken_i, ret_delay_slot_i;
  logic dacc_valid_i, dacc_read_i, dacc_write_i, dcache_on_i, dcache_hit_i, icache_on_i, icache_hit_i;
  logic decode_run_i, execute_run_i, memstage_run_i;
  logic [31:0] ret_instr_i, ret_pc_i, ret_wb_value_i, dacc_addr_i, dacc_wdata_i, dcache_base_i;
  logic [31:0] dcache_high_i, fetch_addr_i, icache_base_i, icache_high_i;
  logic [4:0]  ret_wb_num_i;
  logic [14:0] ret_status_i;
  logic [7:0]  ret_pid_i;
  logic [3:0]  dacc_be_i;
  tpt_kind_t   ret_exc_kind_i, trc_exc_kind_o;
  logic trc_valid_instr_o, trc_reg_write_o, trc_exc_taken_o, trc_kind_fault_o, trc_jump_taken_o;
  logic trc_delay_slot_o, trc_data_access_o, trc_data_read_o, trc_data_write_o, trc_dside_cacheable_o;
  logic trc_dside_hit_o, trc_iside_cacheable_o, trc_iside_hit_o, trc_decode_advance_o;
  logic trc_execute_advance_o, trc_memstage_advance_o;
  logic [31:0] trc_instruction_o, trc_program_counter_o, trc_reg_value_o, trc_data_addr_o, trc_data_wvalue_o;
  logic [4:0]  trc_reg_num_o;
  logic [14:0] trc_status_snapshot_o;
  logic [7:0]  trc_process_id_o;
  logic [3:0]  trc_data_be_o;
  logic [15:0] retire_cnt, exc_cnt, ret_n, exc_n;
  integer      seed, error_cnt, num_checks;
  tpt_note_s   notes[$];

  tpt_trace_port uut (.clock_i, .rst_b_i, .ret_valid_i, .ret_instr_i, .ret_pc_i, .ret_wb_en_i, .ret_wb_num_i,
    .ret_wb_value_i, .ret_status_i, .ret_pid_i, .ret_exc_i, .ret_exc_kind_i, .ret_branch_taken_i,
    .ret_delay_slot_i, .dacc_valid_i, .dacc_addr_i, .dacc_wdata_i, .dacc_be_i, .dacc_read_i, .dacc_write_i,
    .dcache_on_i, .dcache_base_i, .dcache_high_i, .dcache_hit_i, .fetch_addr_i, .icache_on_i, .icache_base_i,
    .icache_high_i, .icache_hit_i, .decode_run_i, .execute_run_i, .memstage_run_i, .trc_valid_instr_o,
    .trc_instruction_o, .trc_program_counter_o, .trc_reg_write_o, .trc_reg_num_o, .trc_reg_value_o,
    .trc_status_snapshot_o, .trc_process_id_o, .trc_exc_taken_o, .trc_exc_kind_o, .trc_kind_fault_o,
    .trc_jump_taken_o, .trc_delay_slot_o, .trc_data_access_o, .trc_data_addr_o, .trc_data_wvalue_o,
    .trc_data_be_o, .trc_data_read_o, .trc_data_write_o, .trc_dside_cacheable_o, .trc_dside_hit_o,
    .trc_iside_cacheable_o, .trc_iside_hit_o, .trc_decode_advance_o, .trc_execute_advance_o,
    .trc_memstage_advance_o);

  tpt_trace_sink sink (.clock_i, .rst_b_i, .valid_i(trc_valid_instr_o), .exc_taken_i(trc_exc_taken_o),
    .retire_cnt_o(retire_cnt), .exc_cnt_o(exc_cnt));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic kind_ok(input logic [4:0] k);
    return (k <= 5'h07) || (k >= 5'h0a && k <= 5'h0c) || (k >= 5'h10 && k <= 5'h13);
  endfunction

  // small address spans so the cache ranges are hit and missed alike
  task automatic step(input logic fx, input tpt_kind_t k);
    logic [31:0] r[10];
    tpt_note_s   n;
    logic        da;
    @(posedge clock_i);
    foreach (r[i]) r[i] = $random(seed);
    {ret_valid_i, ret_wb_en_i, ret_exc_i, ret_branch_taken_i, ret_delay_slot_i, dacc_valid_i, dacc_read_i,
     dacc_write_i, dcache_on_i, dcache_hit_i, icache_on_i, icache_hit_i, decode_run_i, execute_run_i,
     memstage_run_i} <= fx ? {3'b111, r[0][11:0]} : r[0][14:0];
    ret_exc_kind_i <= fx ? k : r[0][20:16];
    {ret_wb_num_i, dacc_be_i} <= r[0][29:21];
    {ret_status_i, ret_pid_i} <= r[1][22:0];
    {ret_instr_i, ret_pc_i} <= {r[2], r[3]};
    {ret_wb_value_i, dacc_wdata_i} <= {r[4], r[5]};
    {dacc_addr_i, fetch_addr_i} <= {r[6] & 32'h1ff, r[7] & 32'h1ff};
    {dcache_base_i, dcache_high_i} <= {r[8] & 32'hff, r[9] & 32'h1ff};
    {icache_base_i, icache_high_i} <= {r[9] & 32'hff, r[8] & 32'h1ff};
    #1;
    if (ret_valid_i === 1'b1) begin
      da = dacc_valid_i & (dacc_read_i ^ dacc_write_i);
      n.w = {ret_instr_i, ret_pc_i, ret_status_i, ret_pid_i};
      n.f = {ret_wb_en_i, ret_exc_i & kind_ok(ret_exc_kind_i), ret_exc_i & !kind_ok(ret_exc_kind_i),
             ret_branch_taken_i, ret_delay_slot_i, da, da & dacc_read_i, da & dacc_write_i, 4'h0,
             decode_run_i, execute_run_i, memstage_run_i};
      n.f[6] = dcache_on_i && dcache_base_i <= dacc_addr_i && dacc_addr_i <= dcache_high_i;
      n.f[5] = n.f[6] & dcache_hit_i;
      n.f[4] = icache_on_i && icache_base_i <= fetch_addr_i && fetch_addr_i <= icache_high_i;
      n.f[3] = n.f[4] & icache_hit_i;
      n.wb = {ret_wb_num_i, ret_wb_value_i};
      n.kind = ret_exc_kind_i;
      n.d = {dacc_addr_i, dacc_wdata_i, dacc_be_i};
      ret_n++;
      exc_n = exc_n + {15'h0000, n.f[13]};
      notes.push_back(n);
    end
  endtask

  initial begin
    tpt_note_s n;
    forever begin
      @(posedge clock_i);
      #1;
      if (trc_valid_instr_o !== 1'b1) begin
        chk({trc_reg_write_o, trc_exc_taken_o, trc_jump_taken_o, trc_data_access_o}, 128'h0);
      end else if (notes.size() == 0) begin
        chk(128'h1, 128'h0);
      end else begin
        n = notes.pop_front();
        chk({trc_instruction_o, trc_program_counter_o, trc_status_snapshot_o, trc_process_id_o}, n.w);
        chk({trc_reg_write_o, trc_exc_taken_o, trc_kind_fault_o, trc_jump_taken_o, trc_delay_slot_o,
             trc_data_access_o, trc_data_read_o, trc_data_write_o, trc_dside_cacheable_o, trc_dside_hit_o,
             trc_iside_cacheable_o, trc_iside_hit_o, trc_decode_advance_o, trc_execute_advance_o,
             trc_memstage_advance_o}, n.f);
        if (n.f[14]) chk({trc_reg_num_o, trc_reg_value_o}, n.wb);
        if (n.f[13]) chk(trc_exc_kind_o, n.kind);
        if (n.f[9]) chk({trc_data_addr_o, trc_data_wvalue_o, trc_data_be_o}, n.d);
      end
    end
  end

  initial begin
    repeat (3000) @(posedge clock_i);
    error_cnt++;
    $display("timeout");
    end_sim();
  end

  initial begin
    seed = 75251;
    error_cnt = 0;
    num_checks = 0;
    ret_n = 16'h0000;
    exc_n = 16'h0000;
    rst_b_i = 1'b0;
    {ret_valid_i, ret_wb_en_i, ret_exc_i, ret_branch_taken_i, ret_delay_slot_i, dacc_valid_i, dacc_read_i,
     dacc_write_i, dcache_on_i, dcache_hit_i, icache_on_i, icache_hit_i, decode_run_i, execute_run_i,
     memstage_run_i, ret_exc_kind_i, ret_wb_num_i, dacc_be_i, ret_status_i, ret_pid_i, ret_instr_i, ret_pc_i,
     ret_wb_value_i, dacc_wdata_i, dacc_addr_i, fetch_addr_i, dcache_base_i, dcache_high_i, icache_base_i,
     icache_high_i} = '0;
    repeat (2) @(posedge clock_i);
    #1;
    chk({trc_valid_instr_o, trc_program_counter_o, trc_exc_kind_o, trc_data_addr_o}, 128'h0);
    $display("test reset done");
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 32; k++) step(1'b1, tpt_kind_t'(k));
    $display("test kind sweep done");
    repeat (400) step(1'b0, 5'h00);
    @(posedge clock_i);
    ret_valid_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #2;
    chk(notes.size(), 0);
    chk({retire_cnt, exc_cnt}, {ret_n, exc_n});
    $display("test random traffic done");
    end_sim();
  end
endmodule
